// ### core/io_port_bank.sv
module io_port_bank #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [3:0] idx,
  input wire logic [31:0] wdata,
  input wire logic [WIDTH-1:0] level,
  output sysio_pkg::pad_cfg_t cfg,
  output logic [31:0] rdata
);

  // Per-line option words, one entry per register index below IDX_LEVEL
  logic [WIDTH-1:0] cfg_q [sysio_pkg::CFG_COUNT];
  // Read view widened to the bus
  logic [31:0] word [sysio_pkg::CFG_COUNT];

  // Widen each word, upper lines read zero
  for (genvar i = 0; i < sysio_pkg::CFG_COUNT; i++) begin : g_word
    assign word[i] = 32'(cfg_q[i]);
  end

  // Pull-up and Schmitt come up enabled, everything else off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < sysio_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= sysio_pkg::CFG_RESET_ZERO[WIDTH-1:0];
      end
      cfg_q[sysio_pkg::IDX_PULL_UP] <= sysio_pkg::CFG_RESET_ONES[WIDTH-1:0];
      cfg_q[sysio_pkg::IDX_SCHMITT] <= sysio_pkg::CFG_RESET_ONES[WIDTH-1:0];
    end else if (wr_en && idx < 4'(sysio_pkg::CFG_COUNT)) begin
      // Each option word programmable line by line
      cfg_q[idx] <= wdata[WIDTH-1:0];
    end
  end

  // Option bundle toward the pad mux
  assign cfg.out = word[sysio_pkg::IDX_OUT];
  assign cfg.oe = word[sysio_pkg::IDX_OE];
  assign cfg.periph = word[sysio_pkg::IDX_PERIPH];
  assign cfg.pull_up = word[sysio_pkg::IDX_PULL_UP];
  assign cfg.pull_down = word[sysio_pkg::IDX_PULL_DOWN];
  assign cfg.schmitt = word[sysio_pkg::IDX_SCHMITT];
  assign cfg.multi = word[sysio_pkg::IDX_MULTI];
  assign cfg.glitch = word[sysio_pkg::IDX_GLITCH];
  assign cfg.debounce = word[sysio_pkg::IDX_DEBOUNCE];
  assign cfg.chg_irq = word[sysio_pkg::IDX_CHG_IRQ];

  // Read selection, line levels at the last index, zero beyond
  assign rdata = (idx < 4'(sysio_pkg::CFG_COUNT)) ? word[idx] :
                 (idx == sysio_pkg::IDX_LEVEL) ? 32'(level) :
                 32'h00000000;

endmodule

// ### core/system_io_line_select.sv
// Contract
// - Shared pins switch between system and I/O
// - After reset system functions are selected
// - Bit 12 picks erase input or line twelve
// - Bits 7,6,5 pick debug functions or lines
// - Pad options programmable per line
// - Line driven directly or by its peripheral
// - Line state held in backup, reset input pull-up
// - Erase input active high, pull-down at reset
// - Port lines reset with pull-up and Schmitt; port B line twelve here comes up with pull-down and Schmitt, no pull-up
// - Debug pin pad options apply in both modes
//
// Local design decisions: the register addresses and the plain strobed port.
module system_io_line_select (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic backup_mode,
  input wire logic [31:0] port_a_in,
  input wire logic [14:0] port_b_in,
  input wire logic [31:0] port_c_in,
  input wire logic [31:0] periph_a_out,
  input wire logic [31:0] periph_a_oe,
  input wire logic [14:0] periph_b_out,
  input wire logic [14:0] periph_b_oe,
  input wire logic [31:0] periph_c_out,
  input wire logic [31:0] periph_c_oe,
  input wire logic dbg_tdo_out,
  input wire logic dbg_tdo_oe,
  input wire logic dbg_swdio_out,
  input wire logic dbg_swdio_oe,
  output sysio_pkg::pad_drive_t port_a_pad,
  output sysio_pkg::pad_drive_t port_b_pad,
  output sysio_pkg::pad_drive_t port_c_pad,
  output logic [31:0] port_a_level,
  output logic [14:0] port_b_level,
  output logic [31:0] port_c_level,
  output logic flash_erase_cmd,
  output logic dbg_tck,
  output logic dbg_tms_in
);

  // Two-stage synchronisers for the pad inputs
  logic [31:0] a_meta_q;
  logic [31:0] a_sync_q;
  logic [14:0] b_meta_q;
  logic [14:0] b_sync_q;
  logic [31:0] c_meta_q;
  logic [31:0] c_sync_q;
  // System select bits
  logic [31:0] sysio_q;
  // Registered outputs
  logic [31:0] rdata_q;
  sysio_pkg::pad_drive_t pad_a_q;
  sysio_pkg::pad_drive_t pad_b_q;
  sysio_pkg::pad_drive_t pad_c_q;
  logic erase_q;
  logic tck_q;
  logic tms_q;

  // Address decode
  wire port_hit = (addr[11:8] == 4'h0);
  wire [1:0] port_sel = addr[7:6];
  wire [3:0] reg_idx = addr[5:2];
  wire sysio_hit = (addr == sysio_pkg::SYSIO_SEL_OFFSET);
  wire status_hit = (addr == sysio_pkg::SYS_STATUS_OFFSET);
  // Writes are ignored while the line state is frozen in backup
  wire wr_ok = wr && !backup_mode;
  wire wr_a = wr_ok && port_hit && (port_sel == sysio_pkg::PORT_A_SEL);
  wire wr_b = wr_ok && port_hit && (port_sel == sysio_pkg::PORT_B_SEL);
  wire wr_c = wr_ok && port_hit && (port_sel == sysio_pkg::PORT_C_SEL);
  wire wr_sysio = wr_ok && sysio_hit;

  // Per-line select: zero keeps the system function
  wire erase_sys = !sysio_q[sysio_pkg::SEL_ERASE_BIT];
  wire tck_sys = !sysio_q[sysio_pkg::SEL_TCK_BIT];
  wire tms_sys = !sysio_q[sysio_pkg::SEL_TMS_BIT];
  wire tdo_sys = !sysio_q[sysio_pkg::SEL_TDO_BIT];

  // Option bundles and read words from the port banks
  sysio_pkg::pad_cfg_t cfg_a;
  sysio_pkg::pad_cfg_t cfg_b;
  sysio_pkg::pad_cfg_t cfg_c;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic [31:0] rd_c;

  // Port A configuration
  io_port_bank #(.WIDTH(sysio_pkg::PORT_A_W)) u_bank_a (
    .clk(clk),
    .rstn(rstn),
    .wr_en(wr_a),
    .idx(reg_idx),
    .wdata(wdata),
    .level(a_sync_q),
    .cfg(cfg_a),
    .rdata(rd_a)
  );

  // Port B configuration
  io_port_bank #(.WIDTH(sysio_pkg::PORT_B_W)) u_bank_b (
    .clk(clk),
    .rstn(rstn),
    .wr_en(wr_b),
    .idx(reg_idx),
    .wdata(wdata),
    .level(b_sync_q),
    .cfg(cfg_b),
    .rdata(rd_b)
  );

  // Port C configuration
  io_port_bank #(.WIDTH(sysio_pkg::PORT_C_W)) u_bank_c (
    .clk(clk),
    .rstn(rstn),
    .wr_en(wr_c),
    .idx(reg_idx),
    .wdata(wdata),
    .level(c_sync_q),
    .cfg(cfg_c),
    .rdata(rd_c)
  );

  // System override on port B; ports A and C carry none
  sysio_pkg::sys_ovr_t ovr_b;
  sysio_pkg::sys_ovr_t ovr_none;
  assign ovr_none = '0;
  assign ovr_b.own = {19'h00000, erase_sys, 4'h0, tck_sys, tms_sys, tdo_sys, 5'h00};
  assign ovr_b.out = {25'h0000000, dbg_swdio_out, dbg_tdo_out, 5'h00};
  // Erase and test clock are inputs; data lines follow the debug logic
  assign ovr_b.oe = {24'h000000, 1'b0, tms_sys && dbg_swdio_oe,
                     tdo_sys && dbg_tdo_oe, 5'h00};
  // Erase input keeps its pull-down while it is selected
  assign ovr_b.pull_down = {19'h00000, erase_sys, 12'h000};

  // Builds the pad drive of one port from options, peripheral and override
  function automatic sysio_pkg::pad_drive_t pad_mux(
    input sysio_pkg::pad_cfg_t cfg,
    input logic [31:0] p_out,
    input logic [31:0] p_oe,
    input sysio_pkg::sys_ovr_t ovr
  );
    sysio_pkg::pad_drive_t d;
    logic [31:0] src_out;
    logic [31:0] src_oe;
    // Peripheral or direct control per line
    src_out = (cfg.periph & p_out) | (~cfg.periph & cfg.out);
    src_oe = (cfg.periph & p_oe) | (~cfg.periph & cfg.oe);
    // Multi-drive lines only pull low
    d.out = src_out & ~cfg.multi;
    d.oe = src_oe & ~(cfg.multi & src_out);
    // System function takes the driver of its line
    d.out = (ovr.own & ovr.out) | (~ovr.own & d.out);
    d.oe = (ovr.own & ovr.oe) | (~ovr.own & d.oe);
    // Pad options stay in force in either mode, but the selected erase line is forced to pull-down and Schmitt, no pull-up
    d.pull_down = cfg.pull_down | ovr.pull_down;
    d.pull_up = cfg.pull_up & ~ovr.pull_down;
    d.schmitt = cfg.schmitt | ovr.pull_down;
    d.glitch = cfg.glitch;
    d.debounce = cfg.debounce;
    d.chg_irq = cfg.chg_irq;
    return d;
  endfunction

  // Next pad drives
  sysio_pkg::pad_drive_t pad_a_d;
  sysio_pkg::pad_drive_t pad_b_d;
  sysio_pkg::pad_drive_t pad_c_d;
  assign pad_a_d = pad_mux(cfg_a, periph_a_out, periph_a_oe, ovr_none);
  assign pad_b_d = pad_mux(cfg_b, {17'h00000, periph_b_out},
                           {17'h00000, periph_b_oe}, ovr_b);
  assign pad_c_d = pad_mux(cfg_c, periph_c_out, periph_c_oe, ovr_none);

  // Read data selection
  wire [31:0] status_word = {30'h00000000, backup_mode, erase_q};
  wire [31:0] rdata_d = !rd ? 32'h00000000 :
                        (port_hit && port_sel == sysio_pkg::PORT_A_SEL) ? rd_a :
                        (port_hit && port_sel == sysio_pkg::PORT_B_SEL) ? rd_b :
                        (port_hit && port_sel == sysio_pkg::PORT_C_SEL) ? rd_c :
                        sysio_hit ? sysio_q :
                        status_hit ? status_word :
                        32'h00000000;

  // Pad input synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_meta_q <= 32'h00000000;
      a_sync_q <= 32'h00000000;
      b_meta_q <= 15'h0000;
      b_sync_q <= 15'h0000;
      c_meta_q <= 32'h00000000;
      c_sync_q <= 32'h00000000;
    end else begin
      a_meta_q <= port_a_in;
      a_sync_q <= a_meta_q;
      b_meta_q <= port_b_in;
      b_sync_q <= b_meta_q;
      c_meta_q <= port_c_in;
      c_sync_q <= c_meta_q;
    end
  end

  // Select register, all system functions after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysio_q <= sysio_pkg::SYSIO_SEL_RESET;
    end else if (wr_sysio) begin
      sysio_q <= wdata & sysio_pkg::SYSIO_SEL_MASK;
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pad drives, frozen while in backup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_a_q <= '0;
      pad_b_q <= '0;
      pad_c_q <= '0;
    end else if (!backup_mode) begin
      pad_a_q <= pad_a_d;
      pad_b_q <= pad_b_d;
      pad_c_q <= pad_c_d;
    end
  end

  // System function inputs, quiet while the line is in I/O use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      erase_q <= 1'b0;
      tck_q <= 1'b0;
      tms_q <= 1'b0;
    end else begin
      // Erase request, active high; outside keeps it low at startup
      erase_q <= erase_sys && b_sync_q[sysio_pkg::SEL_ERASE_BIT];
      tck_q <= tck_sys && b_sync_q[sysio_pkg::SEL_TCK_BIT];
      tms_q <= tms_sys && b_sync_q[sysio_pkg::SEL_TMS_BIT];
    end
  end

  // Output connections
  assign rdata = rdata_q;
  assign port_a_pad = pad_a_q;
  assign port_b_pad = pad_b_q;
  assign port_c_pad = pad_c_q;
  assign port_a_level = a_sync_q;
  assign port_b_level = b_sync_q;
  assign port_c_level = c_sync_q;
  assign flash_erase_cmd = erase_q;
  assign dbg_tck = tck_q;
  assign dbg_tms_in = tms_q;

endmodule

// ### inc/sysio_pkg.sv
package sysio_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Line counts of the three parallel I/O ports
  localparam int PORT_A_W = 32;
  localparam int PORT_B_W = 15;
  localparam int PORT_C_W = 32;

  // Port register windows, one 64-byte block per port
  localparam logic [1:0] PORT_A_SEL = 2'h0;
  localparam logic [1:0] PORT_B_SEL = 2'h1;
  localparam logic [1:0] PORT_C_SEL = 2'h2;

  // Register index inside a port window (byte offset is index times four)
  localparam logic [3:0] IDX_OUT = 4'h0;
  localparam logic [3:0] IDX_OE = 4'h1;
  localparam logic [3:0] IDX_PERIPH = 4'h2;
  localparam logic [3:0] IDX_PULL_UP = 4'h3;
  localparam logic [3:0] IDX_PULL_DOWN = 4'h4;
  localparam logic [3:0] IDX_SCHMITT = 4'h5;
  localparam logic [3:0] IDX_MULTI = 4'h6;
  localparam logic [3:0] IDX_GLITCH = 4'h7;
  localparam logic [3:0] IDX_DEBOUNCE = 4'h8;
  localparam logic [3:0] IDX_CHG_IRQ = 4'h9;
  localparam logic [3:0] IDX_LEVEL = 4'hA;
  localparam int CFG_COUNT = 10;

  // System registers
  localparam logic [ADDR_W-1:0] SYSIO_SEL_OFFSET = 12'h100;
  localparam logic [ADDR_W-1:0] SYS_STATUS_OFFSET = 12'h104;

  // Select bit positions of the shared system pins
  localparam int SEL_ERASE_BIT = 12;
  localparam int SEL_TCK_BIT = 7;
  localparam int SEL_TMS_BIT = 6;
  localparam int SEL_TDO_BIT = 5;
  localparam logic [DATA_W-1:0] SYSIO_SEL_MASK = 32'h000010E0;
  localparam logic [DATA_W-1:0] SYSIO_SEL_RESET = 32'h00000000;

  // Status bit positions
  localparam int STAT_ERASE_BIT = 0;
  localparam int STAT_BACKUP_BIT = 1;

  // Values after reset of port configuration words
  localparam logic [DATA_W-1:0] CFG_RESET_ONES = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] CFG_RESET_ZERO = 32'h00000000;

  // Configuration of one port, lines above the port width read zero
  typedef struct packed {
    logic [31:0] chg_irq;
    logic [31:0] debounce;
    logic [31:0] glitch;
    logic [31:0] multi;
    logic [31:0] schmitt;
    logic [31:0] pull_down;
    logic [31:0] pull_up;
    logic [31:0] periph;
    logic [31:0] oe;
    logic [31:0] out;
  } pad_cfg_t;

  // Drive bundle toward the pads of one port
  typedef struct packed {
    logic [31:0] chg_irq;
    logic [31:0] debounce;
    logic [31:0] glitch;
    logic [31:0] schmitt;
    logic [31:0] pull_down;
    logic [31:0] pull_up;
    logic [31:0] oe;
    logic [31:0] out;
  } pad_drive_t;

  // Override that a system function places on a port
  typedef struct packed {
    logic [31:0] own;
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pull_down;
  } sys_ovr_t;

endpackage

// ### verif/system_io_line_select_monitor.sv
module system_io_line_select_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic backup_mode,
  input wire logic [14:0] port_b_in,
  input wire logic dbg_tdo_out,
  input wire logic dbg_tdo_oe,
  input wire sysio_pkg::pad_drive_t port_a_pad,
  input wire sysio_pkg::pad_drive_t port_b_pad,
  input wire logic flash_erase_cmd,
  input wire logic dbg_tck,
  input wire logic dbg_tms_in
);
  logic [31:0] sel_q; // Mirror of the select register
  logic [31:0] sel_d; // Its next value
  logic [2:0] calm_q; // Edges since select last moved
  logic calm; // Select and syncs settled
  logic sel_rd; // Read of select register
  logic st_rd; // Read of status register
  assign sel_d = (wr && !backup_mode && addr == sysio_pkg::SYSIO_SEL_OFFSET) ?
    (wdata & sysio_pkg::SYSIO_SEL_MASK) : sel_q;
  assign calm = calm_q > 3'h3;
  assign sel_rd = rd && addr == sysio_pkg::SYSIO_SEL_OFFSET;
  assign st_rd = rd && addr == sysio_pkg::SYS_STATUS_OFFSET;
  // Follow select writes, count quiet edges up to seven
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= '0;
      calm_q <= '0;
    end else begin
      sel_q <= sel_d;
      calm_q <= (sel_d != sel_q) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not zero outside read slot");
  a_sel_read_back: assert property ($past(sel_rd) |-> rdata == $past(sel_q))
    else $error("select register read back wrong");
  a_status_read: assert property ($past(st_rd) |->
    rdata[1:0] == {$past(backup_mode), $past(flash_erase_cmd)}) else $error("status wrong");
  a_erase_follows_pin: assert property (calm && !sel_q[12] |->
    flash_erase_cmd == $past(port_b_in[12], 3)) else $error("erase command not following pin");
  a_erase_io_quiet: assert property (calm && sel_q[12] |-> !flash_erase_cmd)
    else $error("erase command while line in io mode");
  a_tck_follows: assert property (calm |->
    dbg_tck == (!sel_q[7] && $past(port_b_in[7], 3))) else $error("test clock wrong");
  a_tms_follows: assert property (calm |->
    dbg_tms_in == (!sel_q[6] && $past(port_b_in[6], 3))) else $error("mode select wrong");
  a_tdo_drive: assert property (calm && !sel_q[5] |->
    port_b_pad.oe[5] == $past(dbg_tdo_oe) && port_b_pad.out[5] == $past(dbg_tdo_out))
    else $error("debug data out not driving line five");
  a_erase_pad_pull: assert property (calm && !sel_q[12] |->
    port_b_pad.pull_down[12] && !port_b_pad.pull_up[12] && !port_b_pad.oe[12])
    else $error("erase pad not input with pull down");
  a_backup_freeze: assert property (calm && $past(backup_mode) |-> $stable(port_a_pad))
    else $error("pads moved in backup mode");
  c_erase_io: cover property (sel_q[12]);
  c_erase_cmd: cover property (flash_erase_cmd);
  c_status_rd: cover property (st_rd);
  c_backup_wr: cover property (backup_mode && wr);
endmodule

bind system_io_line_select system_io_line_select_monitor mon (.clk, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .backup_mode, .port_b_in, .dbg_tdo_out, .dbg_tdo_oe, .port_a_pad,
  .port_b_pad, .flash_erase_cmd, .dbg_tck, .dbg_tms_in);

// ### verif/tb_system_io_line_select.sv
module tb_system_io_line_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, backup_mode = 1'h0;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, port_a_in = '0, port_c_in = '0, rdata, port_a_level, port_c_level;
  logic [31:0] periph_a_out = '0, periph_a_oe = '0, periph_c_out = '0, periph_c_oe = '0;
  logic [14:0] port_b_in = '0, periph_b_out = '0, periph_b_oe = '0, port_b_level;
  logic dbg_tdo_out = 1'h0, dbg_tdo_oe = 1'h0, dbg_swdio_out = 1'h0, dbg_swdio_oe = 1'h0;
  logic flash_erase_cmd, dbg_tck, dbg_tms_in;
  sysio_pkg::pad_drive_t port_a_pad, port_b_pad, port_c_pad;
  int errors = 0, total_checks = 0;
  logic [31:0] lf = 32'h6A92, sel_m = '0, sel, a0, a1; // Random state, model select
  logic [31:0] cfg_m [3][16]; // Model of port configuration words
  int bt [4] = '{12, 7, 6, 5}; // Shared select bits
  system_io_line_select dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .backup_mode,
    .port_a_in, .port_b_in, .port_c_in, .periph_a_out, .periph_a_oe, .periph_b_out,
    .periph_b_oe, .periph_c_out, .periph_c_oe, .dbg_tdo_out, .dbg_tdo_oe, .dbg_swdio_out,
    .dbg_swdio_oe, .port_a_pad, .port_b_pad, .port_c_pad, .port_a_level, .port_b_level,
    .port_c_level, .flash_erase_cmd, .dbg_tck, .dbg_tms_in);
  // Free running clock
  initial begin
    forever #20 clk = ~clk;
  end
  // Next random word
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected read data of a configuration or select word
  function automatic logic [31:0] mdl(input logic [11:0] a);
    if (a == sysio_pkg::SYSIO_SEL_OFFSET) return sel_m;
    if (a[11:6] < 6'h3 && a[5:2] < 4'hA) return cfg_m[a[7:6]][a[5:2]] &
      ((a[7:6] == 2'h1) ? 32'h00007FFF : 32'hFFFFFFFF);
    return 32'h0;
  endfunction
  // Pad field of port A for a configuration index
  function automatic logic [31:0] afield(input int i);
    case (i)
      3: return port_a_pad.pull_up;
      4: return port_a_pad.pull_down;
      5: return port_a_pad.schmitt;
      7: return port_a_pad.glitch;
      8: return port_a_pad.debounce;
      default: return port_a_pad.chg_irq;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // One write cycle, model follows unless backup holds it off
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    if (!backup_mode && a == sysio_pkg::SYSIO_SEL_OFFSET) sel_m = d & sysio_pkg::SYSIO_SEL_MASK;
    if (!backup_mode && a[11:6] < 6'h3 && a[5:2] < 4'hA) cfg_m[a[7:6]][a[5:2]] = d;
  endtask
  // One read cycle, data checked in the following cycle
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pad state expected two cycles after any reset release
  task automatic chk_rst();
    chk(port_a_pad.pull_up, 32'hFFFFFFFF);
    chk(port_a_pad.schmitt, 32'hFFFFFFFF);
    chk(port_a_pad.oe, 32'h0);
    chk(port_c_pad.pull_up & port_c_pad.schmitt, 32'hFFFFFFFF);
    chk(port_b_pad.pull_up, 32'h00006FFF);
    chk(port_b_pad.pull_down, 32'h00001000);
    chk(port_b_pad.schmitt, 32'h00007FFF);
    rd_chk(sysio_pkg::SYSIO_SEL_OFFSET, 32'h0);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("BAD %0t timeout", $time);
    close_out();
  end
  // Main sequence
  initial begin
    foreach (cfg_m[p, i]) cfg_m[p][i] = '0;
    repeat (16) @(posedge clk); // Line twelve held low here
    rstn <= 1'h1;
    settle(2);
    chk_rst();
    $display("test reset done");
    // Each pad option but multi-drive written with random bits, read back and seen at the pads
    for (int k = 3; k < 10; k++) begin
      if (k == 6) continue;
      lf = nx(lf);
      wr_reg({6'h0, k[3:0], 2'h0}, lf);
      rd_chk({6'h0, k[3:0], 2'h0}, mdl({6'h0, k[3:0], 2'h0}));
      settle(2);
      chk(afield(k), lf);
    end
    $display("test pad options done");
    // Direct drive, then peripheral drive
    lf = nx(lf);
    wr_reg(12'h000, lf);
    wr_reg(12'h004, ~lf);
    settle(2);
    chk(port_a_pad.out, lf);
    chk(port_a_pad.oe, ~lf);
    wr_reg(12'h008, 32'hFFFFFFFF);
    wr_reg(12'h088, 32'hFFFFFFFF);
    periph_a_out <= nx(lf);
    periph_a_oe <= lf;
    periph_c_out <= ~lf;
    periph_c_oe <= nx(nx(lf));
    settle(2);
    chk(port_a_pad.out, periph_a_out);
    chk(port_a_pad.oe, periph_a_oe);
    chk(port_c_pad.out, periph_c_out);
    chk(port_c_pad.oe, periph_c_oe);
    $display("test drive done");
    // Shared pins; io enables differ from the debug enables on every shared line
    wr_reg(12'h044, 32'h00001080);
    wr_reg(12'h040, 32'h000010E0);
    wr_reg(12'h050, 32'h000000E0);
    dbg_tdo_oe <= 1'h1;
    dbg_tdo_out <= 1'h1;
    dbg_swdio_oe <= 1'h1;
    port_b_in <= 15'h7FFF;
    for (int i = 0; i < 5; i++) begin
      sel = (i < 4) ? (32'h1 << bt[i]) : 32'h0;
      wr_reg(sysio_pkg::SYSIO_SEL_OFFSET, sel);
      rd_chk(sysio_pkg::SYSIO_SEL_OFFSET, mdl(sysio_pkg::SYSIO_SEL_OFFSET));
      settle(4);
      chk({flash_erase_cmd, dbg_tck, dbg_tms_in, port_b_pad.oe[5]},
        4'hF & ~{sel[12], sel[7], sel[6], sel[5]});
      chk(port_b_pad.oe & 32'h000010E0,
        (sel & 32'h00001080) | (~sel & 32'h00000060));
      chk(port_b_pad.out[6], sel[6]);
      chk(port_b_pad.pull_down & 32'h000010E0, 32'hE0 | (~sel & 32'h1000));
    end
    rd_chk(sysio_pkg::SYS_STATUS_OFFSET, 32'h1);
    port_b_in <= 15'h0;
    $display("test shared pins done");
    // Synchronised levels, line twelve kept low
    lf = nx(lf);
    port_a_in <= lf;
    port_b_in <= lf[14:0] & 15'h6FFF;
    port_c_in <= ~lf;
    settle(3);
    chk(port_a_level, port_a_in);
    chk(port_b_level, port_b_in);
    chk(port_c_level, port_c_in);
    rd_chk(12'h028, port_a_in);
    // Backup freezes pads and drops writes
    backup_mode <= 1'h1;
    settle(2);
    a0 = port_a_pad.pull_up;
    a1 = port_a_pad.out;
    periph_a_out <= ~periph_a_out;
    wr_reg(12'h00C, 32'h0);
    settle(3);
    chk(port_a_pad.pull_up, a0);
    chk(port_a_pad.out, a1);
    rd_chk(sysio_pkg::SYS_STATUS_OFFSET, 32'h2);
    backup_mode <= 1'h0;
    rd_chk(12'h00C, mdl(12'h00C));
    // Unmapped places read zero
    wr_reg(12'h0C0, lf);
    rd_chk(12'h0C0, 32'h0);
    rd_chk(12'h02C, 32'h0);
    $display("test backup done");
    // Second reset with io mode selected
    wr_reg(sysio_pkg::SYSIO_SEL_OFFSET, 32'hFFFFFFFF);
    @(posedge clk);
    rstn <= 1'h0;
    sel_m = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    settle(2);
    chk_rst();
    $display("test second reset done");
    close_out();
  end
endmodule
